//--- logic/pm_cfg_pkg.sv
// Constants and carrier types for the power-management configuration bank.
// Assumes a single 10 MHz core clock and a byte-addressed config space.
package pm_cfg_pkg;
  // ----------------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFF_RELEASE_DELAY = 8'hA8;
  localparam logic [7:0]  OFF_ROUTE_TABLE   = 8'hB8;
  localparam logic [7:0]  OFF_TRAP_FORWARD  = 8'hC0;
  localparam logic [5:0]  DELAY_CODE_RESET  = 6'h0D;
  localparam logic [31:0] ROUTE_RESET       = 32'h0000_0000;
  localparam logic [3:0]  FORWARD_RESET     = 4'h0;
  localparam int          DELAY_CODE_LSB    = 0;
  localparam int          FORWARD_LSB       = 4;

  // ----------------------------------------------------------------------
  // Route codes and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_MGMT = 2'h1;
  localparam logic [1:0] ROUTE_ACPI = 2'h2;
  localparam int         CLK_PERIOD_NS  = 100;
  localparam int         DELAY_STEP_NS  = 3900;
  localparam int         DELAY_STEP_CYC = (DELAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         NUM_MONITORS   = 4;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic        lpc_target;
  } io_cycle_t;

  typedef struct packed {
    logic [NUM_MONITORS-1:0][15:0] base;
    logic [NUM_MONITORS-1:0][3:0]  mask;
  } trap_cfg_t;

  typedef struct packed {
    logic [5:0]              delay_code;
    logic [31:0]             route;
    logic [3:0]              forward;
    logic [31:0]             rdata;
    logic [11:0]             rel_cnt;
    logic                    sleep_n;
    logic                    halt_n;
    logic                    mgmt_irq_n;
    logic                    acpi_irq;
    logic                    wake;
    logic [NUM_MONITORS-1:0] trap_hit;
    logic                    lpc_fwd;
  } state_t;
endpackage : pm_cfg_pkg

//--- logic/trap_decoder.sv
// Address decoder for one I/O trap monitor.
// Assumes base and mask are held stable by registers outside this block.
`timescale 1ns/100ps
module trap_decoder (
  // Clock and reset, used by the checks only.
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  // Decode inputs.
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] base_in,
  input  wire logic [3:0]  mask_in,
  // Result.
  output logic             hit_out
);
  // --------------------------------------------------------------------
  // Masked compare
  // --------------------------------------------------------------------
  // Full 16-bit compare, masked low bits ignored.
  assign hit_out = ((addr_in ^ base_in) & ~{12'h000, mask_in}) == 16'h0000;

  // Hit only on exact unmasked match.
  a_masked_match: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    hit_out == (addr_in[15:4] == base_in[15:4]
                && ((addr_in[3:0] ^ base_in[3:0]) & ~mask_in) == 4'h0))
    else $error("trap decode mismatch");
endmodule : trap_decoder

//--- logic/pm_cfg_bank.sv
// Power-management configuration bank: release delay, input routing and
// trap forwarding. Assumes config accesses and status inputs are synchronous
// to core_clk_in and that trap base/mask registers live outside.
`timescale 1ns/100ps
// What this block does
// - Six-bit delay code sets sleep-release to clock-halt-release interval.
// - Delay code resets to 0Dh, about 47 microseconds.
// - Code 3Fh gives the longest interval, about 242 microseconds.
// - Code two gives the shortest interval, about 3.9 microseconds.
// - Route table holds two bits per input, input n at bits 2n+1:2n.
// - Set, enabled event status raises the interrupt its route selects.
// - Route 00 none, 01 management irq, 10 ACPI irq, 11 reserved.
// - Route has no effect when the pin is not an input.
// - In sleep states an enabled input wakes even with route 00.
// - Route bits of unimplemented pins are not implemented.
// - Forwarding depends on decode hit and forward bits, not irq enables.
// - Forwarding needs the address to pass base and mask decode.
// - Forward bits 7..4 enable monitors 3..0; zero blocks forwarding.
// - Each monitor compares a 16-bit I/O base.
// - Set mask bits exclude matching low address bits from compare.
// - Trapped LPC cycles raise management irq, forward only if enabled.
// - Reserved bits read zero and ignore writes.
module pm_cfg_bank #(
  parameter logic [15:0] IMPL_INPUTS = 16'hFFFF
) (
  // Clock and reset.
  input  wire logic                  core_clk_in,
  input  wire logic                  rstn_in,
  // Configuration space access.
  input  pm_cfg_pkg::cfg_req_t       cfg_req_in,
  output logic [31:0]                cfg_rdata_out,
  // Processor sleep sequencing.
  input  wire logic                  sleep_entry_in,
  output logic                       processor_sleep_n_out,
  output logic                       processor_clock_halt_n_out,
  // General-purpose input events.
  input  wire logic [15:0]           input_event_status_in,
  input  wire logic [15:0]           input_event_enable_in,
  input  wire logic [15:0]           pin_is_input_in,
  input  wire logic                  sleep_state_in,
  output logic                       system_mgmt_irq_n_out,
  output logic                       acpi_event_irq_out,
  output logic                       wake_event_out,
  // I/O trap monitors.
  input  pm_cfg_pkg::io_cycle_t      io_cycle_in,
  input  pm_cfg_pkg::trap_cfg_t      trap_cfg_in,
  output logic [3:0]                 trap_hit_out,
  output logic                       lpc_forward_out
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Route field of input n; unimplemented pins always read as no route.
  function automatic logic [1:0] route_of(input logic [31:0] tbl, input int n);
    route_of = IMPL_INPUTS[n] ? tbl[2*n +: 2] : pm_cfg_pkg::ROUTE_NONE;
  endfunction : route_of

  // Route table mask, two bits per implemented input.
  function automatic logic [31:0] impl_route_mask();
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      m[2*i +: 2] = {2{IMPL_INPUTS[i]}};
    end
    impl_route_mask = m;
  endfunction : impl_route_mask

  localparam logic [31:0] ROUTE_MASK = impl_route_mask();

  pm_cfg_pkg::state_t q;
  pm_cfg_pkg::state_t d;
  logic [3:0]         dec_hit;
  logic [15:0]        mgmt_src;
  logic [15:0]        acpi_src;
  logic [15:0]        wake_src;
  logic [11:0]        rel_load;
  logic [5:0]         steps;

  // --------------------------------------------------------------------
  // Trap decoders, one per monitor
  // --------------------------------------------------------------------
  for (genvar m = 0; m < pm_cfg_pkg::NUM_MONITORS; m++) begin : g_mon
    trap_decoder u_dec (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .addr_in     (io_cycle_in.addr),
      .base_in     (trap_cfg_in.base[m]),
      .mask_in     (trap_cfg_in.mask[m]),
      .hit_out     (dec_hit[m])
    );
  end

  // --------------------------------------------------------------------
  // Event sources and release count
  // --------------------------------------------------------------------
  // Qualify status with enable and input direction, then route.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      mgmt_src[i] = input_event_status_in[i] && input_event_enable_in[i] && pin_is_input_in[i]
                    && route_of(q.route, i) == pm_cfg_pkg::ROUTE_MGMT;
      acpi_src[i] = input_event_status_in[i] && input_event_enable_in[i] && pin_is_input_in[i]
                    && route_of(q.route, i) == pm_cfg_pkg::ROUTE_ACPI;
      wake_src[i] = input_event_status_in[i] && input_event_enable_in[i]
                    && pin_is_input_in[i] && IMPL_INPUTS[i];
    end
  end

  // One step per code above one; forbidden codes clamp to one step.
  assign steps    = (q.delay_code > 6'h01) ? q.delay_code - 6'h01 : 6'h01;
  assign rel_load = 12'(steps * pm_cfg_pkg::DELAY_STEP_CYC - 1);

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  // Registers, sequencer and interrupt levels all update here.
  always_comb begin
    d = q;
    // Delay field in byte 0; bits 7:6 are not stored.
    if (cfg_req_in.wr && cfg_req_in.addr == pm_cfg_pkg::OFF_RELEASE_DELAY
        && cfg_req_in.be[0]) begin
      d.delay_code = cfg_req_in.wdata[pm_cfg_pkg::DELAY_CODE_LSB +: 6];
    end
    // Byte-enabled table write; unimplemented fields stay zero.
    if (cfg_req_in.wr && cfg_req_in.addr == pm_cfg_pkg::OFF_ROUTE_TABLE) begin
      for (int b = 0; b < 4; b++) begin
        if (cfg_req_in.be[b]) begin
          d.route[8*b +: 8] = cfg_req_in.wdata[8*b +: 8] & ROUTE_MASK[8*b +: 8];
        end
      end
    end
    // Only bits 7:4 are held; 3:0 are reserved.
    if (cfg_req_in.wr && cfg_req_in.addr == pm_cfg_pkg::OFF_TRAP_FORWARD
        && cfg_req_in.be[0]) begin
      d.forward = cfg_req_in.wdata[pm_cfg_pkg::FORWARD_LSB +: 4];
    end
    // Read data is captured so the answer is a clean flop output.
    if (cfg_req_in.rd) begin
      case (cfg_req_in.addr)
        pm_cfg_pkg::OFF_RELEASE_DELAY: d.rdata = {26'h0, q.delay_code};
        pm_cfg_pkg::OFF_ROUTE_TABLE:   d.rdata = q.route;
        pm_cfg_pkg::OFF_TRAP_FORWARD:  d.rdata = {24'h0, q.forward, 4'h0};
        default:                       d.rdata = 32'h0000_0000;
      endcase
    end
    // Sleep release first, clock-halt release after the count.
    if (sleep_entry_in) begin
      d.sleep_n = 1'b0;
      d.halt_n  = 1'b0;
      d.rel_cnt = 12'h000;
    end else if (!q.sleep_n) begin
      d.sleep_n = 1'b1;
      d.rel_cnt = rel_load;
    end else if (!q.halt_n) begin
      if (q.rel_cnt == 12'h000) begin
        d.halt_n = 1'b1;
      end else begin
        d.rel_cnt = q.rel_cnt - 12'h001;
      end
    end
    // Management irq from routed inputs or any trapped cycle.
    d.trap_hit = io_cycle_in.valid ? dec_hit : 4'h0;
    d.mgmt_irq_n = !((|mgmt_src) || (|d.trap_hit));
    d.acpi_irq   = |acpi_src;
    // Wake needs an enabled, implemented input in sleep, regardless of route.
    d.wake     = sleep_state_in && (|wake_src);
    // Forward on a valid LPC cycle's decode hit and its forward bit.
    d.lpc_fwd  = io_cycle_in.valid && io_cycle_in.lpc_target && (|(dec_hit & q.forward));
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  // Reset loads the default delay code and releases both signals.
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      q            <= '0;
      q.delay_code <= pm_cfg_pkg::DELAY_CODE_RESET;
      q.route      <= pm_cfg_pkg::ROUTE_RESET;
      q.forward    <= pm_cfg_pkg::FORWARD_RESET;
      q.sleep_n    <= 1'b1;
      q.halt_n     <= 1'b1;
      q.mgmt_irq_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign cfg_rdata_out              = q.rdata;
  assign processor_sleep_n_out      = q.sleep_n;
  assign processor_clock_halt_n_out = q.halt_n;
  assign system_mgmt_irq_n_out      = q.mgmt_irq_n;
  assign acpi_event_irq_out         = q.acpi_irq;
  assign wake_event_out             = q.wake;
  assign trap_hit_out               = q.trap_hit;
  assign lpc_forward_out            = q.lpc_fwd;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  // Cycles since sleep release, for the interval check.
  logic [11:0] since_rel;
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || !q.sleep_n || q.halt_n) begin
      since_rel <= 12'h000;
    end else begin
      since_rel <= since_rel + 12'h001;
    end
  end

  sequence s_sleep_released;
    $rose(q.sleep_n) && !q.halt_n;
  endsequence

  // Halt release never coincides with sleep release.
  a_halt_follows_sleep: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_sleep_released |=> !q.halt_n || $fell(q.sleep_n) || !q.sleep_n)
    else $error("clock halt released with sleep");

  a_release_interval: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(q.halt_n) && q.sleep_n && !$past(sleep_entry_in)
      |-> since_rel == 12'(int'(steps) * pm_cfg_pkg::DELAY_STEP_CYC))
    else $error("release interval wrong");

  a_default_code: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(rstn_in) |-> q.delay_code == pm_cfg_pkg::DELAY_CODE_RESET)
    else $error("delay code not default after reset");

  a_mgmt_route: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (|mgmt_src) |=> !system_mgmt_irq_n_out)
    else $error("routed event missed management irq");

  // ACPI irq level tracks its sources.
  a_acpi_route: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    ##1 acpi_event_irq_out == $past(|acpi_src))
    else $error("acpi irq mismatch");

  a_output_pin_quiet: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (pin_is_input_in == 16'h0000 && !io_cycle_in.valid)
      |=> system_mgmt_irq_n_out && !acpi_event_irq_out && !wake_event_out)
    else $error("non-input pin caused an event");

  // Enabled input wakes in sleep even unrouted.
  a_wake_unrouted: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (sleep_state_in && (|wake_src)) |=> wake_event_out)
    else $error("wake event missed");

  a_unimpl_zero: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (q.route & ~ROUTE_MASK) == 32'h0000_0000)
    else $error("unimplemented route bits set");

  // Forwarded cycle was trapped, enabled and raised irq.
  a_forward_gate: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    lpc_forward_out |-> (|(q.trap_hit & $past(q.forward))) && !system_mgmt_irq_n_out)
    else $error("forward without enabled trap");

  // Bits a read of each offset may return set; all others are reserved.
  function automatic logic [31:0] rd_impl_mask(input logic [7:0] addr);
    case (addr)
      pm_cfg_pkg::OFF_RELEASE_DELAY: rd_impl_mask = 32'h0000_003F;
      pm_cfg_pkg::OFF_ROUTE_TABLE:   rd_impl_mask = ROUTE_MASK;
      pm_cfg_pkg::OFF_TRAP_FORWARD:  rd_impl_mask = 32'h0000_00F0;
      default:                       rd_impl_mask = 32'h0000_0000;
    endcase
  endfunction : rd_impl_mask

  a_reserved_zero: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $past(cfg_req_in.rd) |-> (cfg_rdata_out & ~rd_impl_mask($past(cfg_req_in.addr)))
      == 32'h0000_0000)
    else $error("reserved bits read nonzero");
endmodule : pm_cfg_bank

//--- bench/pm_far_side_model.sv
// Far-side model: processor sleep and clock-halt pins and an LPC target.
// Assumes it samples the block's registered outputs on the rising edge.
`timescale 1ns/100ps
module pm_far_side_model (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Pins from the block.
  input  wire logic        sleep_n_in,
  input  wire logic        halt_n_in,
  input  wire logic        lpc_forward_in,
  // Observations for the bench.
  output logic [11:0]      release_cnt_out,
  output logic [7:0]       fwd_cnt_out
);
  // ----------------------------------------------------------------------
  // Pin observation
  // ----------------------------------------------------------------------
  // Counts edges from sleep release to halt release; the count freezes once
  // both are released, so the bench may read it late without losing it.
  always_ff @(posedge clk_in) begin
    if (!rstn_in || !sleep_n_in) begin
      release_cnt_out <= 12'h000;
    end else if (!halt_n_in) begin
      release_cnt_out <= release_cnt_out + 12'h001;
    end
  end

  // The LPC target claims every forwarded cycle and counts it.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      fwd_cnt_out <= 8'h00;
    end else begin
      fwd_cnt_out <= fwd_cnt_out + {7'h00, lpc_forward_in};
    end
  end
endmodule : pm_far_side_model

//--- bench/pm_clock_delay_gpi_route_trap_fwd_tb.sv
// Self-checking bench for the power-management configuration bank.
// Assumes the far-side model watches the sleep, halt and forward pins.
`timescale 1ns/100ps
module pm_clock_delay_gpi_route_trap_fwd_tb;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic                  clk         = 1'b0;
  logic                  rstn        = 1'b0;
  pm_cfg_pkg::cfg_req_t  req         = '0;
  logic                  sleep_entry = 1'b0;
  logic [15:0]           ev_sts      = 16'h0000;
  logic [15:0]           ev_en       = 16'h0000;
  logic [15:0]           pin_in      = 16'hFFFF;
  logic                  sleep_st    = 1'b0;
  pm_cfg_pkg::io_cycle_t io          = '0;
  pm_cfg_pkg::trap_cfg_t tcfg        = '0;
  logic [31:0]           rdata;
  logic                  sleep_n, halt_n, mgmt_irq_n, acpi_irq, wake, fwd;
  logic [3:0]            hit;
  logic [11:0]           rel_cnt;
  logic [7:0]            fwd_cnt;
  int                    error_cnt   = 0;
  int                    check_count = 0;

  // Input 15 is left out so the missing route field can be seen.
  pm_cfg_bank #(.IMPL_INPUTS(16'h7FFF)) u_dut (
    .core_clk_in               (clk),
    .rstn_in                   (rstn),
    .cfg_req_in                (req),
    .cfg_rdata_out             (rdata),
    .sleep_entry_in            (sleep_entry),
    .processor_sleep_n_out     (sleep_n),
    .processor_clock_halt_n_out(halt_n),
    .input_event_status_in     (ev_sts),
    .input_event_enable_in     (ev_en),
    .pin_is_input_in           (pin_in),
    .sleep_state_in            (sleep_st),
    .system_mgmt_irq_n_out     (mgmt_irq_n),
    .acpi_event_irq_out        (acpi_irq),
    .wake_event_out            (wake),
    .io_cycle_in               (io),
    .trap_cfg_in               (tcfg),
    .trap_hit_out              (hit),
    .lpc_forward_out           (fwd)
  );

  pm_far_side_model u_far (
    .clk_in         (clk),
    .rstn_in        (rstn),
    .sleep_n_in     (sleep_n),
    .halt_n_in      (halt_n),
    .lpc_forward_in (fwd),
    .release_cnt_out(rel_cnt),
    .fwd_cnt_out    (fwd_cnt)
  );

  // The clock toggles every half period of 100 ns.
  always #50 clk = ~clk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%08h exp=%08h", $time, got, exp);
    end
  endtask : chk

  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, be, d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : cfg_wr

  // Read data is registered, so it is taken one edge after the strobe.
  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 4'hF, 32'h0000_0000};
    @(negedge clk);
    req.rd = 1'b0;
    d = rdata;
  endtask : cfg_rd

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0]  a [4]  = '{8'hA8, 8'hB8, 8'hC0, 8'hD0};
    logic [31:0] r0 [4] = '{32'h0000_000D, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    logic [31:0] r1 [4] = '{32'h0000_003F, 32'h3FFF_FFFF, 32'h0000_00F0, 32'h0000_0000};
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      cfg_rd(a[i], v);
      chk(v, r0[i]);
      cfg_wr(a[i], 32'hFFFF_FFFF, 4'hF);
      cfg_rd(a[i], v);
      chk(v, r1[i]);
    end
    cfg_wr(8'hB8, 32'h0000_0000, 4'hF);
  endtask : t_regs

  task automatic t_delay(input logic [5:0] code, input logic do_wr);
    int k;
    if (do_wr) begin
      cfg_wr(8'hA8, {26'h0, code}, 4'h1);
    end
    sleep_entry = 1'b1;
    repeat (2) @(negedge clk);
    chk({30'h0, sleep_n, halt_n}, 32'h0000_0000);
    sleep_entry = 1'b0;
    for (k = 0; k < 3000 && halt_n !== 1'b1; k++) begin
      @(negedge clk);
    end
    chk({20'h0, rel_cnt}, 32'((int'(code) - 1) * pm_cfg_pkg::DELAY_STEP_CYC));
  endtask : t_delay

  // Input 3 is routed through every code, then every pin is made a non-input.
  task automatic t_route();
    for (int c = 0; c < 4; c++) begin
      cfg_wr(8'hB8, {24'h0, 2'(c), 6'h0}, 4'hF);
      ev_sts = 16'h0008;
      ev_en = 16'h0008;
      @(negedge clk);
      chk({30'h0, mgmt_irq_n, acpi_irq}, {30'h0, c != 1, c == 2});
      pin_in = 16'h0000;
      @(negedge clk);
      chk({30'h0, mgmt_irq_n, acpi_irq}, 32'h0000_0002);
      pin_in = 16'hFFFF;
      ev_sts = 16'h0000;
    end
    cfg_wr(8'hB8, 32'h0000_0000, 4'hF);
    sleep_st = 1'b1;
    ev_sts = 16'h0008;
    @(negedge clk);
    chk({31'h0, wake}, 32'h0000_0001);
    ev_en = 16'h0000;
    @(negedge clk);
    chk({31'h0, wake}, 32'h0000_0000);
    sleep_st = 1'b0;
    ev_sts = 16'h0000;
  endtask : t_route

  // Pass 0 enables only this monitor, pass 1 all others, pass 2 misses,
  // pass 3 enables this monitor but the cycle is not aimed at LPC.
  task automatic t_trap();
    logic [7:0] n0;
    n0 = fwd_cnt;
    for (int m = 0; m < 4; m++) begin
      tcfg.base[m] = {4'(m + 1), 12'h230};
      tcfg.mask[m] = 4'h3;
    end
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 4; p++) begin
        cfg_wr(8'hC0, {24'h0, (p == 0 || p == 3) ? (4'h1 << m) : ~(4'h1 << m), 4'h0}, 4'h1);
        io = '{1'b1, tcfg.base[m] + ((p == 2) ? 16'h0004 : 16'h0003), p != 3};
        @(negedge clk);
        io.valid = 1'b0;
        chk({28'h0, hit}, (p == 2) ? 32'h0 : 32'(4'h1 << m));
        chk({30'h0, fwd, mgmt_irq_n}, (p == 0) ? 32'h2 : 32'(p == 2));
      end
    end
    chk({24'h0, fwd_cnt - n0}, 32'h0000_0004);
  endtask : t_trap

  task automatic final_report();
    $display("Summary: checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t_delay(6'h0D, 1'b0);
    t_regs();
    t_delay(6'h02, 1'b1);
    t_delay(6'h3F, 1'b1);
    t_route();
    t_trap();
    final_report();
  end

  // The tests need about 3,000 cycles; the limit leaves ample margin.
  initial begin
    repeat (10000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule : pm_clock_delay_gpi_route_trap_fwd_tb
